// >>> core/loopback_activity_interrupt_regs.sv
// Loopback enables, line clock activity monitor and interrupt status bank
`timescale 1ns/100ps
module loopback_activity_interrupt_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System-side buses, one byte lane and slot index per slice
  input wire logic [31:0] drop_data,
  input wire logic [15:0] drop_slot,
  input wire logic [31:0] add_bus_data,
  output logic [31:0] add_sys_data,
  // Line clocks taken after the line interfaces, async to pclk
  input wire logic [3:0] rx_line_clk,
  input wire logic [3:0] tx_line_clk,
  // Add frame pulse pin and decoded markers
  input wire logic add_frame_pulse_in,
  output logic add_j0_mark,
  output logic add_payload_mark,
  output logic add_interp_en,
  // Interrupt sources, levels from blocks on pclk
  input wire logic [6:0] glb_src,
  input wire logic [14:0] s1_src,
  input wire logic [12:0] s2_src,
  output logic irq_out_n
);

  logic [3:0][11:0] lb_q;
  logic [7:0] act_q;
  logic [7:0] act_mask_q;
  logic [7:0] act_set;
  logic [2:0] group_irq_enable_q;
  logic pos_sel_q;
  logic pulse_mask_q;
  logic bypass_q;
  logic [3:0] rx_s1_q, rx_s2_q, rx_s3_q;
  logic [3:0] tx_s1_q, tx_s2_q, tx_s3_q;
  logic fp_s1_q, fp_s2_q;
  logic [15:0] glb_word, s1_word, s2_word;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic irq_n_q;
  logic [5:0] idx;
  logic setup_ph, access_ph, wr_acc, rd_acc;

  // Bus phase decode
  assign idx = paddr[7:2];
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc = access_ph && pwrite && !pslverr_q;
  assign rd_acc = access_ph && !pwrite;
  // Zero wait states: the answer is prepared during setup
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Status words follow their sources directly
  assign glb_word = {group_irq_enable_q[0], 8'h00, glb_src}; // R11 R12
  assign s1_word = {group_irq_enable_q[1], s1_src}; // R14 R12
  assign s2_word = {group_irq_enable_q[2], 1'b0, s2_src[12:10], 1'b0,
                    s2_src[9:0]}; // R15 R12

  // Address map check, shared by read mux and error decode
  function automatic logic is_mapped(input logic [5:0] i,
                                     input logic [1:0] lo);
    is_mapped = (lo == 2'b00) &&
                ((i >= lb_act_pkg::IDX_LB0 && i <= lb_act_pkg::IDX_LB3) ||
                 i == lb_act_pkg::IDX_ACT || i == lb_act_pkg::IDX_GLB ||
                 i == lb_act_pkg::IDX_S1 || i == lb_act_pkg::IDX_S2 ||
                 i == lb_act_pkg::IDX_ADD_CFG ||
                 i == lb_act_pkg::IDX_MISC ||
                 i == lb_act_pkg::IDX_INTERP ||
                 i == lb_act_pkg::IDX_ACT_MASK);
  endfunction

  // Read multiplexer; unused and reserved bits read zero
  function automatic logic [15:0] rd_word(input logic [5:0] i);
    logic [15:0] w;
    w = 16'h0000;
    case (i)
      lb_act_pkg::IDX_LB0: w = {4'h0, lb_q[0]}; // R2
      lb_act_pkg::IDX_LB1: w = {4'h0, lb_q[1]}; // R2
      lb_act_pkg::IDX_LB2: w = {4'h0, lb_q[2]}; // R2
      lb_act_pkg::IDX_LB3: w = {4'h0, lb_q[3]}; // R2
      lb_act_pkg::IDX_ACT: w = {8'h00, act_q};
      lb_act_pkg::IDX_GLB: w = glb_word;
      lb_act_pkg::IDX_S1: w = s1_word;
      lb_act_pkg::IDX_S2: w = s2_word;
      lb_act_pkg::IDX_ADD_CFG: w[lb_act_pkg::POS_SEL_BIT] = pos_sel_q;
      lb_act_pkg::IDX_MISC: w[lb_act_pkg::PULSE_MASK_BIT] = pulse_mask_q;
      lb_act_pkg::IDX_INTERP: w[lb_act_pkg::BYPASS_BIT] = bypass_q;
      lb_act_pkg::IDX_ACT_MASK: w = {8'h00, act_mask_q};
      default: w = 16'h0000;
    endcase
    rd_word = w;
  endfunction

  // Read data and error captured in setup, shown in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      // Refused reads return zero, so they cannot clear activity flags
      if (pwrite || !is_mapped(idx, paddr[1:0])) begin
        prdata_q <= 32'h0000_0000;
      end else begin
        prdata_q <= {16'h0000, rd_word(idx)};
      end
      pslverr_q <= !is_mapped(idx, paddr[1:0]);
    end
  end

  // Read answers are captured at setup and must stand through access
  lb_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    setup_ph && !pwrite && paddr == {lb_act_pkg::IDX_LB1, 2'b00}
    |=> prdata_q[15:0] == {4'h0, $past(lb_q[1])})
    else $error("loopback read wrong");
  act_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    setup_ph && !pwrite && paddr == {lb_act_pkg::IDX_ACT, 2'b00}
    |=> prdata_q[7:0] == $past(act_q) && prdata_q[15:8] == 8'h00)
    else $error("activity read wrong");
  s1_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    setup_ph && !pwrite && paddr == {lb_act_pkg::IDX_S1, 2'b00}
    |=> prdata_q[14:0] == $past(s1_src) &&
        prdata_q[15] == $past(group_irq_enable_q[1]))
    else $error("slice one status read wrong");
  // A refused transfer must answer with an error and no data
  err_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && paddr[1:0] != 2'b00
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("misaligned access not refused");
  write_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && pwrite |=> prdata == 32'h0000_0000)
    else $error("write returned read data");

  // Loopback enable registers, one per slice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_q <= {4{lb_act_pkg::LB_RST}};
    end else if (wr_acc) begin
      for (int s = 0; s < lb_act_pkg::N_SLICE; s++) begin
        if (idx == lb_act_pkg::IDX_LB0 + 6'(s)) begin
          lb_q[s] <= pwdata[11:0]; // R2
        end
      end
    end
  end

  // Group enables and configuration bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_irq_enable_q <= {3{lb_act_pkg::GROUP_IRQ_ENABLE_RST}};
      pos_sel_q <= lb_act_pkg::CFG_BIT_RST;
      pulse_mask_q <= lb_act_pkg::CFG_BIT_RST;
      bypass_q <= lb_act_pkg::CFG_BIT_RST;
      act_mask_q <= lb_act_pkg::ACT_MASK_RST;
    end else if (wr_acc) begin
      case (idx)
        lb_act_pkg::IDX_GLB: group_irq_enable_q[0] <= pwdata[lb_act_pkg::GROUP_IRQ_ENABLE_BIT];
        lb_act_pkg::IDX_S1: group_irq_enable_q[1] <= pwdata[lb_act_pkg::GROUP_IRQ_ENABLE_BIT];
        lb_act_pkg::IDX_S2: group_irq_enable_q[2] <= pwdata[lb_act_pkg::GROUP_IRQ_ENABLE_BIT];
        lb_act_pkg::IDX_ADD_CFG: pos_sel_q <= pwdata[lb_act_pkg::POS_SEL_BIT];
        lb_act_pkg::IDX_MISC:
          pulse_mask_q <= pwdata[lb_act_pkg::PULSE_MASK_BIT];
        lb_act_pkg::IDX_INTERP: bypass_q <= pwdata[lb_act_pkg::BYPASS_BIT];
        lb_act_pkg::IDX_ACT_MASK: act_mask_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Enable and configuration writes land on the access edge
  glb_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    wr_acc && idx == lb_act_pkg::IDX_GLB
    |=> group_irq_enable_q[0] == $past(pwdata[lb_act_pkg::GROUP_IRQ_ENABLE_BIT]))
    else $error("global enable write not stored");
  s1_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    wr_acc && idx == lb_act_pkg::IDX_S1
    |=> group_irq_enable_q[1] == $past(pwdata[lb_act_pkg::GROUP_IRQ_ENABLE_BIT]))
    else $error("slice one enable write not stored");
  s2_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    wr_acc && idx == lb_act_pkg::IDX_S2
    |=> group_irq_enable_q[2] == $past(pwdata[lb_act_pkg::GROUP_IRQ_ENABLE_BIT]))
    else $error("slice two enable write not stored");
  cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    wr_acc && idx == lb_act_pkg::IDX_ADD_CFG
    |=> pos_sel_q == $past(pwdata[lb_act_pkg::POS_SEL_BIT]))
    else $error("pulse position write not stored");
  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    wr_acc && idx == lb_act_pkg::IDX_MISC
    |=> pulse_mask_q == $past(pwdata[lb_act_pkg::PULSE_MASK_BIT]))
    else $error("pulse mask write not stored");
  // Refused writes must leave every register as it was
  err_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && pwrite && pslverr_q
    |=> $stable(lb_q) && $stable(group_irq_enable_q) && $stable(act_mask_q))
    else $error("refused write changed a register");

  // Line clock synchronisers; the third stage only feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 4'h0;
      rx_s2_q <= 4'h0;
      rx_s3_q <= 4'h0;
      tx_s1_q <= 4'h0;
      tx_s2_q <= 4'h0;
      tx_s3_q <= 4'h0;
    end else begin
      rx_s1_q <= rx_line_clk; // R10
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      tx_s1_q <= tx_line_clk; // R10
      tx_s2_q <= tx_s1_q;
      tx_s3_q <= tx_s2_q;
    end
  end

  // Rising edges only; line clocks must stay below half of pclk
  assign act_set[3:0] = rx_s2_q & ~rx_s3_q; // R7
  assign act_set[7:4] = tx_s2_q & ~tx_s3_q; // R8

  // Sticky activity flags: a read clears only what it returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= lb_act_pkg::ACT_RST;
    end else if (rd_acc && idx == lb_act_pkg::IDX_ACT) begin
      act_q <= (act_q & ~prdata_q[7:0]) | act_set; // R9
    end else begin
      act_q <= act_q | act_set; // R7 R8
    end
  end

  // Flags set only on an edge, and hold until a read of their register
  rx_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    !act_q[2] && !act_set[2] |=> !act_q[2])
    else $error("rx activity flag set without an edge");
  tx_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !act_q[5] && !act_set[5] |=> !act_q[5])
    else $error("tx activity flag set without an edge");
  rx_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    act_q[1] && !(rd_acc && idx == lb_act_pkg::IDX_ACT) |=> act_q[1])
    else $error("rx activity flag lost without a read");
  tx_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    act_q[4] && !(rd_acc && idx == lb_act_pkg::IDX_ACT) |=> act_q[4])
    else $error("tx activity flag lost without a read");

  // Per-slice loopback multiplexer, one stage of latency
  for (genvar s = 0; s < lb_act_pkg::N_SLICE; s++) begin : g_loop
    logic [3:0] slot;
    logic loop_on;
    assign slot = drop_slot[s*4 +: 4];
    assign loop_on = (slot < 4'(lb_act_pkg::N_PATH)) && lb_q[s][slot];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        add_sys_data[s*8 +: 8] <= 8'h00;
      end else if (loop_on) begin
        add_sys_data[s*8 +: 8] <= drop_data[s*8 +: 8]; // R1
      end else begin
        add_sys_data[s*8 +: 8] <= add_bus_data[s*8 +: 8]; // R3
      end
    end
  end

  // Two more lanes, and slots past the last path, which never loop
  loop_top_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    g_loop[3].loop_on
    |=> add_sys_data[31:24] == $past(drop_data[31:24]))
    else $error("looped top lane did not carry drop data");
  pass_lane_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    !g_loop[2].loop_on
    |=> add_sys_data[23:16] == $past(add_bus_data[23:16]))
    else $error("unlooped lane did not carry add data");
  slot_range_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    drop_slot[3:0] >= 4'(lb_act_pkg::N_PATH)
    |=> add_sys_data[7:0] == $past(add_bus_data[7:0]))
    else $error("slot past the last path was looped");

  // Add frame pulse: mask drops a pin without framing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_s1_q <= 1'b0;
      fp_s2_q <= 1'b0;
      add_j0_mark <= 1'b0;
      add_payload_mark <= 1'b0;
    end else begin
      fp_s1_q <= add_frame_pulse_in;
      fp_s2_q <= fp_s1_q;
      add_j0_mark <= fp_s2_q && !pos_sel_q && !pulse_mask_q; // R16 R4
      add_payload_mark <= fp_s2_q && pos_sel_q && !pulse_mask_q; // R16
    end
  end

  // The J0 position and the mask, which silences both marks
  j0_pos_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    fp_s2_q && !pos_sel_q && !pulse_mask_q |=> add_j0_mark && !add_payload_mark)
    else $error("frame pulse not marked as J0");
  mask_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    pulse_mask_q |=> !add_j0_mark && !add_payload_mark)
    else $error("masked frame pulse still marked");

  // Interpreter enable and interrupt output, both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_interp_en <= 1'b1;
      irq_n_q <= 1'b1;
    end else begin
      add_interp_en <= !bypass_q; // R6
      irq_n_q <= !((group_irq_enable_q[0] && |glb_src) || // R13
                   (group_irq_enable_q[1] && |s1_src) || // R14
                   (group_irq_enable_q[2] && |s2_src) || // R15
                   |(act_q & act_mask_q)); // R17
    end
  end
  assign irq_out_n = irq_n_q;

  // Each enabled group and the masked activity flags reach the pin
  bypass_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    !bypass_q |=> add_interp_en)
    else $error("interpreter disabled without bypass");
  irq_s1_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    group_irq_enable_q[1] && |s1_src |=> !irq_out_n)
    else $error("enabled slice one interrupt not raised");
  irq_s2_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    group_irq_enable_q[2] && |s2_src |=> !irq_out_n)
    else $error("enabled slice two interrupt not raised");
  irq_act_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    |(act_q & act_mask_q) |=> !irq_out_n)
    else $error("unmasked activity interrupt not raised");

  // Checks
  loop_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    g_loop[0].loop_on |=> add_sys_data[7:0] == $past(drop_data[7:0]))
    else $error("looped path did not carry drop data");
  add_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    !g_loop[1].loop_on |=> add_sys_data[15:8] == $past(add_bus_data[15:8]))
    else $error("unlooped path did not carry add data");
  lb_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    wr_acc && idx == lb_act_pkg::IDX_LB2 |=> lb_q[2] == $past(pwdata[11:0]))
    else $error("loopback write not stored");
  rx_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    rx_s2_q[0] && !rx_s3_q[0] |=> act_q[0])
    else $error("rx activity flag not set");
  tx_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    tx_s2_q[3] && !tx_s3_q[3] |=> act_q[7])
    else $error("tx activity flag not set");
  act_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    rd_acc && idx == lb_act_pkg::IDX_ACT && act_set == 8'h00 &&
    act_q == prdata_q[7:0] |=> act_q == 8'h00)
    else $error("activity read did not clear flags");
  glb_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    setup_ph && !pwrite && paddr == {lb_act_pkg::IDX_GLB, 2'b00}
    |=> prdata_q[6:0] == $past(glb_src) && prdata_q[14:7] == 8'h00)
    else $error("global status read wrong");
  s2_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    setup_ph && !pwrite && paddr == {lb_act_pkg::IDX_S2, 2'b00}
    |=> prdata_q[14] == 1'b0 && prdata_q[10] == 1'b0 &&
        prdata_q[13:11] == $past(s2_src[12:10]))
    else $error("slice two status layout wrong");
  irq_glb_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    group_irq_enable_q[0] && |glb_src |=> !irq_out_n)
    else $error("enabled global interrupt not raised");
  irq_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    !(group_irq_enable_q[1] && |s1_src) && !(group_irq_enable_q[0] && |glb_src) &&
    !(group_irq_enable_q[2] && |s2_src) && !(|(act_q & act_mask_q)) |=> irq_out_n)
    else $error("interrupt raised with nothing enabled");
  bypass_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    bypass_q |=> !add_interp_en)
    else $error("interpreter not disabled by bypass");
  pulse_pos_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    fp_s2_q && pos_sel_q && !pulse_mask_q |=> add_payload_mark && !add_j0_mark)
    else $error("frame pulse position wrong");

endmodule

// >>> pkg/lb_act_pkg.sv
// Register map, field layout and reset values of the loopback/activity bank
// Overview of operation
// R1: Enabled path takes drop data onto add
// R2: Four slice loopback registers, twelve enables each
// R3: Disabled path keeps add bus data
// R4: Unframed add pulse needs position and mask
// R5: Software bypasses interpreter beyond twelve cycles offset
// R6: Bypass bit six disables add interpreter
// R7: Receive clock rise sets receive flag
// R8: Transmit clock rise sets transmit flag
// R9: Reading activity register clears all flags; the code clears only the flags the read returned
// R10: Clocks sampled after the line interfaces
// R11: Global status shows seven source blocks
// R12: Status bits follow source, ignoring enables
// R13: Bit fifteen gates global group onto irq
// R14: Slice one has fifteen flags, gated
// R15: Slice two flags skip bits fourteen, ten
// R16: Position select picks J0 or payload
// R17: Irq low while enabled group pending
package lb_act_pkg;
  localparam int IDX_W = 6;
  localparam int N_SLICE = 4;
  localparam int N_PATH = 12;
  localparam int BYTE_W = 8;
  localparam int SLOT_W = 4;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_LB0 = 6'h08;
  localparam logic [5:0] IDX_LB1 = 6'h09;
  localparam logic [5:0] IDX_LB2 = 6'h0a;
  localparam logic [5:0] IDX_LB3 = 6'h0b;
  localparam logic [5:0] IDX_ACT = 6'h0e;
  localparam logic [5:0] IDX_GLB = 6'h0f;
  localparam logic [5:0] IDX_S1 = 6'h10;
  localparam logic [5:0] IDX_S2 = 6'h11;
  localparam logic [5:0] IDX_ADD_CFG = 6'h16;
  localparam logic [5:0] IDX_MISC = 6'h1d;
  localparam logic [5:0] IDX_INTERP = 6'h20;
  localparam logic [5:0] IDX_ACT_MASK = 6'h21;
  // Field positions
  localparam int GROUP_IRQ_ENABLE_BIT = 15;
  localparam int POS_SEL_BIT = 14;
  localparam int PULSE_MASK_BIT = 15;
  localparam int BYPASS_BIT = 6;
  localparam int TX_ACT_LSB = 4;
  // Implemented status bits per register
  localparam logic [15:0] GLB_MASK = 16'h007f;
  localparam logic [15:0] S1_MASK = 16'h7fff;
  localparam logic [15:0] S2_MASK = 16'h3bff;
  // Reset values
  localparam logic [11:0] LB_RST = 12'h000;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [7:0] ACT_MASK_RST = 8'h00;
  localparam logic GROUP_IRQ_ENABLE_RST = 1'b0;
  localparam logic CFG_BIT_RST = 1'b0;
endpackage

// >>> test/loopback_activity_interrupt_regs_bench.sv
// Self-checking bench for the loopback, activity and interrupt bank
`timescale 1ns/100ps
module loopback_activity_interrupt_regs_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, drop_data, add_bus_data;
  logic [31:0] add_sys_data, add_exp;
  logic [15:0] drop_slot;
  logic [3:0] rx_line_clk = '0, tx_line_clk = '0;
  logic pready, pslverr, add_j0_mark, add_payload_mark, add_interp_en;
  logic irq_out_n, add_frame_pulse_in = 0, live = 0;
  logic [6:0] glb_src = '0;
  logic [14:0] s1_src = '0;
  logic [12:0] s2_src = '0;
  logic [47:0] lb_en = '0;
  logic [32:0] expq[$];
  logic [7:0] rst_a [8] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h38, 8'h3c,
    8'h40, 8'h44};
  logic [7:0] grp [3] = '{8'h3c, 8'h40, 8'h44};
  logic [15:0] stat [3] = '{lb_act_pkg::GLB_MASK, lb_act_pkg::S1_MASK,
    lb_act_pkg::S2_MASK};
  int bad_count = 0, checked = 0, j0_cnt = 0, pl_cnt = 0;
  int seed = 42672;
  always #25 pclk = ~pclk;

  loopback_activity_interrupt_regs i_loopback_activity_interrupt_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .drop_data, .drop_slot, .add_bus_data,
    .add_sys_data, .rx_line_clk, .tx_line_clk, .add_frame_pulse_in,
    .add_j0_mark, .add_payload_mark, .add_interp_en, .glb_src, .s1_src,
    .s2_src, .irq_out_n);
  payload_side_model i_payload_side_model (
    .pclk, .lb_en, .drop_data, .drop_slot, .add_bus_data, .add_exp);

  task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One transfer; the expected answer is queued for the watcher
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [32:0] e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // Level outputs, looked at once settled
  task automatic probe(logic [1:0] e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check("irq_en", {31'b0, irq_out_n, add_interp_en}, {31'b0, e});
    @(posedge pclk);
  endtask

  // Slow line clock rise, well inside what the sync chain can see
  task automatic line_pulse(logic [3:0] r, logic [3:0] t);
    rx_line_clk <= r;
    tx_line_clk <= t;
    repeat (4) @(posedge pclk);
    rx_line_clk <= '0;
    tx_line_clk <= '0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic fpulse(int ej, int ep);
    add_frame_pulse_in <= 1'b1;
    @(posedge pclk);
    add_frame_pulse_in <= 1'b0;
    repeat (8) @(posedge pclk);
    check("marks", {1'b0, 16'(j0_cnt), 16'(pl_cnt)},
          {1'b0, 16'(ej), 16'(ep)});
  endtask

  // Each completed transfer is matched to the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && expq.size() > 0)
      check("apb", {pslverr, prdata}, expq.pop_front());

  // Loopback lanes against the model; marks counted as they show
  always @(negedge pclk) begin
    if (live) check("add", {1'b0, add_sys_data}, {1'b0, add_exp});
    j0_cnt += add_j0_mark;
    pl_cnt += add_payload_mark;
  end

  initial begin
    logic [11:0] pat;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    live = 1'b1;
    foreach (rst_a[i]) apb(0, rst_a[i], 0, 33'h0);
    apb(0, 8'h0c, 0, {1'b1, 32'h0});
    apb(0, 8'h39, 0, {1'b1, 32'h0});
    apb(1, 8'h48, 32'hffff_ffff, {1'b1, 32'h0});
    apb(1, 8'h3c, 32'h0000_7fff, 33'h0);
    apb(0, 8'h3c, 0, 33'h0);
    probe(2'b11);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      pat = 12'hfff >> (3 * s);
      apb(1, 8'(8'h20 + 4 * s), 32'hffff_f000 | 32'(pat), 33'h0);
      lb_en[12*s+:12] <= pat;
      apb(0, 8'(8'h20 + 4 * s), 0, {21'h0, pat});
    end
    repeat (40) @(posedge pclk);
    $display("test loopback done");
    line_pulse(4'h2, 4'h4);
    probe(2'b11);
    apb(0, 8'h39, 0, {1'b1, 32'h0});
    apb(0, 8'h38, 0, 33'h42);
    apb(0, 8'h38, 0, 33'h0);
    apb(1, 8'h84, 32'h0000_00ff, 33'h0);
    apb(0, 8'h84, 0, 33'hff);
    line_pulse(4'h1, 4'h8);
    probe(2'b01);
    apb(0, 8'h38, 0, 33'h81);
    probe(2'b11);
    $display("test activity done");
    glb_src <= 7'h7f;
    s1_src <= 15'h7fff;
    s2_src <= 13'h1fff;
    for (int g = 0; g < 3; g++) begin
      apb(0, grp[g], 0, {17'h0, stat[g]});
      apb(1, grp[g], 32'h0000_8000, 33'h0);
      probe(2'b01);
      apb(0, grp[g], 0, {17'h0, stat[g] | 16'h8000});
      apb(1, grp[g], 32'h0, 33'h0);
      probe(2'b11);
    end
    glb_src <= 7'($random(seed));
    s2_src <= 13'($random(seed));
    @(posedge pclk);
    apb(0, 8'h3c, 0, {26'h0, glb_src});
    apb(0, 8'h44, 0, {19'h0, s2_src[12:10], 1'b0, s2_src[9:0]});
    $display("test interrupt done");
    fpulse(1, 0);
    apb(1, 8'h58, 32'h0000_4000, 33'h0);
    apb(0, 8'h58, 0, 33'h4000);
    fpulse(1, 1);
    apb(1, 8'h74, 32'h0000_8000, 33'h0);
    apb(0, 8'h74, 0, 33'h8000);
    fpulse(1, 1);
    apb(1, 8'h80, 32'h0000_0040, 33'h0);
    apb(0, 8'h80, 0, 33'h40);
    probe(2'b10);
    apb(1, 8'h80, 32'h0, 33'h0);
    probe(2'b11);
    $display("test framing done");
    tally_and_finish();
  end
endmodule

// >>> test/payload_side_model.sv
// Far-side payload processor: drives drop and add buses
`timescale 1ns/100ps
module payload_side_model (
  // Clock
  input wire logic pclk,
  // Enables as last written by software
  input wire logic [47:0] lb_en,
  // System-side buses
  output logic [31:0] drop_data,
  output logic [15:0] drop_slot,
  output logic [31:0] add_bus_data,
  // Predicted add data
  output logic [31:0] add_exp
);
  int seed = 42672;
  int k;
  initial begin
    drop_data = '0;
    drop_slot = '0;
    add_bus_data = '0;
    add_exp = '0;
  end
  // Fresh bytes each cycle; slot 12 shows out-of-range slots never loop
  always @(posedge pclk) begin
    for (int s = 0; s < 4; s++) begin
      k = drop_slot[4*s+:4];
      add_exp[8*s+:8] <= (k < 12 && lb_en[12*s+k]) ?
        drop_data[8*s+:8] : add_bus_data[8*s+:8];
      drop_slot[4*s+:4] <= 4'({$random(seed)} % 13);
    end
    drop_data <= $random(seed);
    add_bus_data <= $random(seed);
  end
endmodule
